/* File: design/svwd_top.v */
// supervisor reset logic: supply, manual reset and watchdog causes with reset hold
//
// How it works
// - reset is asserted whenever the supply-good input shows the supply below its threshold.
// - after the supply returns good, reset stays asserted for the full hold period.
// - a low manual_reset_n forces reset for as long as it stays low.
// - after manual_reset_n returns high, reset stays asserted for the full hold period.
// - a watchdog reset fires when watchdog_kick_in holds one level for the whole watchdog period.
// - any rising or falling edge on watchdog_kick_in clears the watchdog timer.
// - the watchdog timer is cleared whenever reset is asserted, whatever the cause.
// - the low-active output is low while reset is asserted and high otherwise.
// - the high-active output is the inverse of the low-active output.
// - on the bidirectional variant another party may pull the shared line low as a reset.
// - a watchdog reset stays asserted for the full hold period.
// - when the hold period ends and reset releases, the watchdog timer restarts from zero.
// - a floating watchdog kick is serviced internally so no watchdog reset occurs.
`timescale 1ns/1ps
`include "svwd_regs.vh"
module svwd_top #(
  parameter WD_CYCLES = `SVWD_WD_CYCLES,
  parameter HOLD_CYCLES = `SVWD_HOLD_CYCLES,
  parameter [1:0] OUT_MODE = `SVWD_OUT_PUSHPULL,
  parameter CW = 24
) (
  // clock and reset
  input wire clk,
  input wire rst,
  // supervised inputs
  input wire supply_good,
  input wire manual_reset_n,
  input wire watchdog_kick_in,
  input wire watchdog_kick_oe,
  input wire reset_line_in,
  // reset outputs
  output reg reset_out_n,
  output reg reset_out,
  output reg reset_line_oe,
  output reg reset_line_out,
  output reg watchdog_fired
);
  // ****************************************
  // input synchronisers
  // ****************************************
  wire supply_good_s;
  wire manual_s;
  wire kick_s;
  wire kick_en_s;
  wire line_s;

  svwd_sync #(.RESET_VAL(1'b0)) u_sync_supply (.clk(clk), .rst(rst), .din(supply_good), .dout(supply_good_s));
  svwd_sync #(.RESET_VAL(1'b1)) u_sync_manual (.clk(clk), .rst(rst), .din(manual_reset_n), .dout(manual_s));
  svwd_sync #(.RESET_VAL(1'b1)) u_sync_kick (.clk(clk), .rst(rst), .din(watchdog_kick_in), .dout(kick_s));
  svwd_sync #(.RESET_VAL(1'b0)) u_sync_kicken (.clk(clk), .rst(rst), .din(watchdog_kick_oe), .dout(kick_en_s));
  svwd_sync #(.RESET_VAL(1'b1)) u_sync_line (.clk(clk), .rst(rst), .din(reset_line_in), .dout(line_s));

  // ****************************************
  // reset cause and hold counter
  // ****************************************
  reg [CW-1:0] hold_q;
  reg [CW-1:0] wd_q;
  reg kick_prev_q;
  reg asserted_q;
  wire wd_expire;
  wire ext_pull;
  wire cause;

  // external pull-down seen whenever asserted_q is low, so our own drive, still in line_s just after release, counts as one
  assign ext_pull = (OUT_MODE == `SVWD_OUT_BIDIR) && !line_s && !asserted_q;
  assign cause = !supply_good_s || !manual_s || ext_pull;
  // expiry after the full period of a constant level
  assign wd_expire = (wd_q == WD_CYCLES[CW-1:0] - 1'b1) && kick_en_s && !asserted_q;

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      hold_q <= {CW{1'b0}};
      asserted_q <= 1'b1;
    end else if (cause || wd_expire) begin
      // hold restarts while any cause remains
      hold_q <= {CW{1'b0}};
      asserted_q <= 1'b1;
    end else if (asserted_q) begin
      if (hold_q == HOLD_CYCLES[CW-1:0] - 1'b1) begin
        asserted_q <= 1'b0;
      end else begin
        hold_q <= hold_q + 1'b1;
      end
    end
  end

  // ****************************************
  // watchdog timer
  // ****************************************
  // a floating kick is treated as serviced; the enable input models the driver state
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      wd_q <= {CW{1'b0}};
      kick_prev_q <= 1'b1;
    end else begin
      kick_prev_q <= kick_s;
      if (asserted_q || cause || wd_expire) begin
        // cleared in reset, counts from zero after release
        wd_q <= {CW{1'b0}};
      end else if (kick_s != kick_prev_q) begin
        wd_q <= {CW{1'b0}};
      end else if (!kick_en_s) begin
        wd_q <= {CW{1'b0}};
      end else begin
        wd_q <= wd_q + 1'b1;
      end
    end
  end

  // ****************************************
  // output stage
  // ****************************************
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      reset_out_n <= 1'b0;
      reset_out <= 1'b1;
      reset_line_oe <= 1'b1;
      reset_line_out <= 1'b0;
      watchdog_fired <= 1'b0;
    end else begin
      reset_out_n <= !(asserted_q || cause || wd_expire);
      reset_out <= asserted_q || cause || wd_expire;
      // open-drain and bidir only sink; push-pull drives both levels
      reset_line_out <= (OUT_MODE == `SVWD_OUT_PUSHPULL) ? !(asserted_q || cause || wd_expire) : 1'b0;
      reset_line_oe <= (OUT_MODE == `SVWD_OUT_PUSHPULL) ? 1'b1 : (asserted_q || cause || wd_expire);
      watchdog_fired <= wd_expire;
    end
  end
endmodule

/* File: design/svwd_regs.vh */
// timing constants and variant codes for the supervisor watchdog reset block
`ifndef SVWD_REGS_VH
`define SVWD_REGS_VH
// clock period in ns (250 MHz)
`define SVWD_CLK_NS 4
// watchdog period and reset hold period, in us
`define SVWD_WD_PERIOD_US 6300
`define SVWD_HOLD_PERIOD_US 1000
// cycle counts derived from the times above (longest time rounds down, least time rounds up)
`define SVWD_WD_CYCLES ((`SVWD_WD_PERIOD_US * 1000) / `SVWD_CLK_NS)
`define SVWD_HOLD_CYCLES ((`SVWD_HOLD_PERIOD_US * 1000 + `SVWD_CLK_NS - 1) / `SVWD_CLK_NS)
// output stage variants
`define SVWD_OUT_PUSHPULL 2'h0
`define SVWD_OUT_OPENDRAIN 2'h1
`define SVWD_OUT_BIDIR 2'h2
// synchroniser reset code (unused; each svwd_sync instance sets its own RESET_VAL, low for supply_good and watchdog_kick_oe)
`define SVWD_SYNC_RESET 2'h3
`endif

/* File: design/svwd_sync.v */
// two-flop synchroniser for asynchronous pin inputs
`timescale 1ns/1ps
module svwd_sync #(
  parameter [0:0] RESET_VAL = 1'b1
) (
  // clock and reset
  input wire clk,
  input wire rst,
  // data
  input wire din,
  output reg dout
);
  reg meta_q;

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      meta_q <= RESET_VAL;
      dout <= RESET_VAL;
    end else begin
      meta_q <= din;
      dout <= meta_q;
    end
  end
endmodule

/* File: tb/svwd_properties.sv */
// port checks for the supervisor reset block
`timescale 1ns/1ps
module svwd_properties #(parameter WD_CYCLES = 50, parameter HOLD_CYCLES = 20) (
  input wire clk, rst, supply_good, manual_reset_n, watchdog_kick_in, watchdog_kick_oe, reset_line_in,
  input wire reset_out_n, reset_out, reset_line_oe, reset_line_out, watchdog_fired);
  reg [15:0] lo_q;
  reg [15:0] calm_q;
  reg k_q;
  // calm counts driven, unchanged kick while released
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      lo_q <= 16'h0;
      calm_q <= 16'h0;
      k_q <= 1'b0;
    end else begin
      k_q <= watchdog_kick_in;
      lo_q <= reset_out_n ? 16'h0 : lo_q + 16'h1;
      calm_q <= (!reset_out_n || !watchdog_kick_oe || k_q != watchdog_kick_in) ? 16'h0 : calm_q + 16'h1;
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  sequence mr_low_s; !manual_reset_n [*5]; endsequence
  sequence sup_low_s; !supply_good [*5]; endsequence
  inv_out_a: assert property (reset_out != reset_out_n) else $error("not inverse");
  manual_force_a: assert property (mr_low_s |-> !reset_out_n) else $error("no manual reset");
  supply_force_a: assert property (sup_low_s |-> !reset_out_n) else $error("no supply reset");
  hold_len_a: assert property ($rose(reset_out_n) |-> lo_q >= HOLD_CYCLES) else $error("short hold");
  wd_reset_a: assert property (watchdog_fired |-> ##[0:2] !reset_out_n) else $error("no wd reset");
  wd_calm_a: assert property (watchdog_fired |-> calm_q >= WD_CYCLES - 2) else $error("early wd");
  wd_clear_a: assert property (!reset_out_n && $past(!reset_out_n) |-> !watchdog_fired) else $error("wd in reset");
  line_drive_a: assert property (reset_line_oe && reset_line_out == reset_out_n) else $error("bad line");
endmodule

/* File: tb/svwd_cpu_model.sv */
// processor model: kick driver that sees reset
`timescale 1ns/1ps
module svwd_cpu_model (
  input wire clk, reset_out_n, kick_en, float_en,
  output reg watchdog_kick_in, output wire watchdog_kick_oe);
  reg [3:0] t_q = 4'h0;
  reg drv_q = 1'b0;
  initial watchdog_kick_in = 1'b0;
  assign watchdog_kick_oe = !float_en;
  // a released line has no pull: it shows the inverse of the driven level and then sits still
  always @(posedge clk) begin
    t_q <= t_q + 4'h1;
    if (float_en) begin
      watchdog_kick_in <= !drv_q;
    end else if (kick_en && reset_out_n && t_q == 4'h0) begin
      drv_q <= !drv_q;
      watchdog_kick_in <= !drv_q;
    end else begin
      watchdog_kick_in <= drv_q;
    end
  end
endmodule

/* File: tb/tb_top.sv */
// self-checking bench for the supervisor reset block
`timescale 1ns/1ps
module tb_top;
  localparam [15:0] WD = 16'h32;
  localparam [15:0] HOLD = 16'h14;
  reg clk = 1'b0, rst = 1'b1, supply_good = 1'b1, manual_reset_n = 1'b1, kick_en = 1'b1, float_en = 1'b0;
  reg fired = 1'b0;
  reg [7:0] lfsr = 8'h41;
  reg [15:0] len = 16'h0;
  reg [16:0] q[$];
  reg [16:0] note;
  integer bad_count = 0, n_checks = 0, i, j;
  wire watchdog_kick_in, watchdog_kick_oe, reset_line_in, reset_out_n, reset_out, reset_line_oe, reset_line_out;
  wire watchdog_fired;
  assign reset_line_in = reset_line_oe ? reset_line_out : 1'b1;
  initial forever #2 clk = !clk;
  // plain 32-bit overrides so the design's part-selects of its periods stay in range
  svwd_top #(.WD_CYCLES(32'h32), .HOLD_CYCLES(32'h14)) svwd_top_inst (.*);
  svwd_cpu_model svwd_cpu_model_inst (.*);
  function [7:0] lfsr_next(input [7:0] v);
    lfsr_next = {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
  endfunction
  task check(input string name, input [15:0] exp, input [15:0] got, input [15:0] tol);
    n_checks = n_checks + 1;
    if ((got >= exp && got <= exp + tol) !== 1'b1) begin
      bad_count = bad_count + 1;
      $display("wrong value %s expected %0d seen %0d", name, exp, got);
    end
  endtask
  task finish_test;
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task wait_done(input string name);
    for (i = 0; i < 2000 && (q.size() > 0 || reset_out_n !== 1'b1); i = i + 1) @(posedge clk);
    if (i == 2000) begin
      bad_count = bad_count + 1;
      finish_test;
    end else $display("test %s done", name);
  endtask
  // each release is compared with the oldest note
  always @(posedge clk) begin
    fired <= (fired | watchdog_fired) & !rst;
    if (rst) len <= 16'h0;
    else if (!reset_out_n) len <= len + 16'h1;
    else if (len != 16'h0) begin
      note = q.size() > 0 ? q.pop_front() : 17'h1FFFF;
      check("low length", note[15:0], len, 16'h8);
      check("wd flag", {15'h0, note[16]}, {15'h0, fired}, 16'h0);
      len <= 16'h0;
      fired <= 1'b0;
    end
  end
  initial begin
    repeat (8) @(posedge clk);
    q.push_back({1'b0, HOLD});
    rst <= 1'b0;
    wait_done("power up");
    for (j = 0; j < 4; j = j + 1) begin
      lfsr = lfsr_next(lfsr);
      q.push_back({1'b0, HOLD + 16'h3 + lfsr[4:0]});
      {supply_good, manual_reset_n} <= j[0] ? 2'h1 : 2'h2;
      repeat (3 + lfsr[4:0]) @(posedge clk);
      {supply_good, manual_reset_n} <= 2'h3;
      wait_done(j[0] ? "supply" : "manual");
    end
    kick_en <= 1'b0;
    q.push_back({1'b1, HOLD});
    wait_done("watchdog");
    kick_en <= 1'b1;
    float_en <= 1'b1;
    repeat (300) @(posedge clk);
    float_en <= 1'b0;
    repeat (300) @(posedge clk);
    wait_done("quiet");
    finish_test;
  end
endmodule
bind svwd_top svwd_properties #(.WD_CYCLES(WD_CYCLES), .HOLD_CYCLES(HOLD_CYCLES)) svwd_properties_inst (.*);
